//--- uabd_pkg.sv
// shared constants for the automatic rate measurement block
package uabd_pkg;
  // =====================================================================
  // register map (word offsets on the plain register port)
  localparam logic [3:0] ADDR_CTRL      = 4'h0;
  localparam logic [3:0] ADDR_RATE_LOW  = 4'h1;
  localparam logic [3:0] ADDR_RATE_HIGH = 4'h2;
  localparam logic [3:0] ADDR_STATUS    = 4'h3;
  localparam logic [3:0] ADDR_RX_HOLD   = 4'h4;
  localparam logic [3:0] ADDR_TX_HOLD   = 4'h5;
  // =====================================================================
  // control register fields
  localparam int CTRL_ARM_BIT    = 0;
  localparam int CTRL_WAKE_BIT   = 1;
  localparam int CTRL_WIDE_BIT   = 3;
  localparam int CTRL_HIGH_BIT   = 4;
  localparam int CTRL_ASYNC_BIT  = 5;
  localparam int CTRL_ROLL_BIT   = 7;
  localparam logic [7:0] CTRL_RESET = 8'h20;
  // =====================================================================
  // status register fields
  localparam int STAT_RXF_BIT   = 0;
  localparam int STAT_IDLE_BIT  = 1;
  localparam int STAT_TXREJ_BIT = 2;
  // =====================================================================
  // counter clock dividers and edge count
  localparam int DIV_SLOW = 512;
  localparam int DIV_MID  = 128;
  localparam int DIV_FAST = 32;
  localparam int CAL_DIV  = 8;
  localparam logic [2:0] LAST_EDGE = 3'h5;
  localparam logic [7:0] CAL_CHAR  = 8'h55;
endpackage

//--- uabd_prescale.sv
// one-cycle enable pulses at the selected measurement counter rate
module uabd_prescale #(
  parameter int MAX_DIV = uabd_pkg::DIV_SLOW * uabd_pkg::CAL_DIV
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // control
  input  wire logic       clear,
  input  wire logic [1:0] sel,
  // enable out
  output logic            tick
);
  initial begin
    if (MAX_DIV < uabd_pkg::DIV_SLOW * uabd_pkg::CAL_DIV) begin
      $error("uabd_prescale: MAX_DIV too small");
    end
  end

  localparam int CW = $clog2(MAX_DIV);
  localparam logic [CW-1:0] TERM_SLOW = CW'(uabd_pkg::DIV_SLOW * uabd_pkg::CAL_DIV - 1);
  localparam logic [CW-1:0] TERM_MID  = CW'(uabd_pkg::DIV_MID * uabd_pkg::CAL_DIV - 1);
  localparam logic [CW-1:0] TERM_FAST = CW'(uabd_pkg::DIV_FAST * uabd_pkg::CAL_DIV - 1);

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic [CW-1:0] term;
  logic          hit;

  // wide/high select: 00 slow, 01 or 10 mid, 11 fast, all at one eighth
  assign term    = (sel == 2'h0) ? TERM_SLOW :
                   (sel == 2'h3) ? TERM_FAST : TERM_MID; // see [RULE10] see [RULE11]
  assign hit     = (cnt_ff >= term);
  assign nxt_cnt = (clear || hit) ? '0 : cnt_ff + CW'(1);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_ff <= '0;
      tick   <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      tick   <= hit && !clear;
    end
  end
endmodule

//--- uabd_edge.sv
// synchroniser and rising edge detector for the serial input pin
module uabd_edge (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // pin
  input  wire logic serial_in_pin,
  // outputs
  output logic      level,
  output logic      rise
);
  logic meta_ff;
  logic sync_ff;
  logic prev_ff;

  // two-stage synchroniser, first stage read only by the second
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta_ff <= 1'b1;
      sync_ff <= 1'b1;
      prev_ff <= 1'b1;
    end else begin
      meta_ff <= serial_in_pin;
      sync_ff <= meta_ff; // see [RULE19]
      prev_ff <= sync_ff;
    end
  end

  assign level = sync_ff;
  assign rise  = sync_ff && !prev_ff;
endmodule

//--- uabd_top.sv
// automatic rate measurement of a serial receiver
// Overview of operation
// [RULE1] measure only in asynchronous mode
// [RULE2] start bit while armed begins measurement
// [RULE3] rate generator becomes a pin-gated counter
// [RULE4] arming clears count, then awaits start bit
// [RULE5] remote sends calibration byte 55h
// [RULE6] counting starts on first rising edge
// [RULE7] fifth rising edge stops, disarms automatically
// [RULE8] rollover sets flag; software sets or clears
// [RULE9] rollover keeps measurement and arm set
// [RULE10] count clocked at one eighth rate
// [RULE11] select 00 /512, 01/10 /128, 11 /32
// [RULE12] count is always sixteen bits wide
// [RULE13] receiver held idle during measurement
// [RULE14] fifth edge sets receive flag; read clears
// [RULE15] with wake set, measure byte after break
// [RULE16] transmit holding writes blocked while armed
// [RULE17] software never arms during transmission
// [RULE18] measures both low and high bit times
// [RULE19] pin synchronised; edge count reset on arm
//
// The implementer's own choices: the address map and the address-and-strobe port.
module uabd_top (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // register port
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // serial side
  input  wire logic       serial_in_pin,
  // status to the rest of the serial port
  output logic            receiver_hold_idle,
  output logic            receive_flag,
  output logic            tx_write_ok,
  output logic      [7:0] tx_data
);
  // =====================================================================
  // states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_START = 2'b01,
    ST_COUNT = 2'b11,
    ST_BREAK = 2'b10
  } uabd_state_t;

  uabd_state_t state_ff;
  uabd_state_t nxt_state;
  logic [7:0]  ctrl_ff;
  logic [15:0] rate_ff;
  logic [15:0] nxt_rate;
  logic [2:0]  edges_ff;
  logic [2:0]  nxt_edges;
  logic        rxf_ff;
  logic        txrej_ff;
  logic        break_seen_ff;

  logic        level;
  logic        rise;
  logic        tick;
  logic        fall;
  logic        prev_level_ff;

  // =====================================================================
  // decoding
  logic wr_ctrl;
  logic wr_low;
  logic wr_high;
  logic wr_stat;
  logic wr_tx;
  logic rd_rx;
  logic arm_set;
  logic allowed;
  logic armed;
  logic fifth;
  logic roll;
  logic clr_cnt;
  logic measuring;
  logic [7:0] ctrl_wr_val;
  logic [7:0] rd_mux;
  logic [7:0] stat_val;

  assign wr_ctrl = reg_wr && (reg_addr == uabd_pkg::ADDR_CTRL);
  assign wr_low  = reg_wr && (reg_addr == uabd_pkg::ADDR_RATE_LOW);
  assign wr_high = reg_wr && (reg_addr == uabd_pkg::ADDR_RATE_HIGH);
  assign wr_stat = reg_wr && (reg_addr == uabd_pkg::ADDR_STATUS);
  assign wr_tx   = reg_wr && (reg_addr == uabd_pkg::ADDR_TX_HOLD);
  assign rd_rx   = reg_rd && (reg_addr == uabd_pkg::ADDR_RX_HOLD);

  assign armed   = ctrl_ff[uabd_pkg::CTRL_ARM_BIT];
  // the mode bit written beside the arm bit decides, not the old one
  assign allowed = wr_ctrl ? reg_wdata[uabd_pkg::CTRL_ASYNC_BIT] :
                             ctrl_ff[uabd_pkg::CTRL_ASYNC_BIT]; // see [RULE1]
  assign arm_set = wr_ctrl && reg_wdata[uabd_pkg::CTRL_ARM_BIT] && !armed;
  assign fall    = !level && prev_level_ff;
  assign measuring = (state_ff != ST_IDLE);
  // fifth rising edge while counting ends the sequence
  assign fifth   = (state_ff == ST_COUNT) && rise &&
                   (edges_ff == uabd_pkg::LAST_EDGE - 3'h1); // see [RULE7] see [RULE18]
  assign roll    = (state_ff == ST_COUNT) && tick && (rate_ff == 16'hffff); // see [RULE8]
  assign clr_cnt = arm_set && allowed; // see [RULE4]

  uabd_prescale u_prescale (
    .clk   (clk),
    .rst_b (rst_b),
    .clear (clr_cnt),
    .sel   ({ctrl_ff[uabd_pkg::CTRL_WIDE_BIT], ctrl_ff[uabd_pkg::CTRL_HIGH_BIT]}),
    .tick  (tick)
  );

  uabd_edge u_edge (
    .clk           (clk),
    .rst_b         (rst_b),
    .serial_in_pin (serial_in_pin),
    .level         (level),
    .rise          (rise)
  );

  // =====================================================================
  // state machine
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_IDLE: begin
        if (clr_cnt) begin
          // wake set: skip the break character first
          nxt_state = reg_wdata[uabd_pkg::CTRL_WAKE_BIT] ? ST_BREAK : ST_START; // see [RULE15]
        end
      end
      ST_BREAK: begin
        // break ends on its rising edge; the next start bit is measured
        if (rise) begin
          nxt_state = ST_START; // see [RULE15]
        end
      end
      ST_START: begin
        // start bit seen, counting begins on first rising edge
        if (rise && break_seen_ff) begin
          nxt_state = ST_COUNT; // see [RULE2] see [RULE6]
        end
      end
      ST_COUNT: begin
        if (fifth) begin
          nxt_state = ST_IDLE;
        end
      end
    endcase
    if (!armed && !clr_cnt) begin
      nxt_state = ST_IDLE;
    end
  end

  // =====================================================================
  // rate count, always one sixteen-bit counter
  always_comb begin
    nxt_rate = rate_ff;
    if (clr_cnt) begin
      nxt_rate = 16'h0000; // see [RULE4]
    end else if ((state_ff == ST_COUNT) && tick) begin
      nxt_rate = rate_ff + 16'h0001; // see [RULE3] see [RULE12] see [RULE9]
    end else if (!measuring && wr_low) begin
      nxt_rate = {rate_ff[15:8], reg_wdata};
    end else if (!measuring && wr_high) begin
      nxt_rate = {reg_wdata, rate_ff[7:0]};
    end
  end

  assign nxt_edges = clr_cnt ? 3'h0 :
                     ((state_ff == ST_START) && rise && break_seen_ff) ? 3'h1 :
                     ((state_ff == ST_COUNT) && rise) ? edges_ff + 3'h1 : edges_ff; // see [RULE19]

  // control write; arm only when allowed, auto-clear on fifth edge, rollover set wins
  always_comb begin
    ctrl_wr_val = wr_ctrl ? reg_wdata : ctrl_ff;
    ctrl_wr_val[uabd_pkg::CTRL_ARM_BIT] = wr_ctrl ?
      (reg_wdata[uabd_pkg::CTRL_ARM_BIT] && allowed) : armed; // see [RULE1]
    if (fifth) begin
      ctrl_wr_val[uabd_pkg::CTRL_ARM_BIT] = 1'b0; // see [RULE7]
    end
    if (roll) begin
      ctrl_wr_val[uabd_pkg::CTRL_ROLL_BIT] = 1'b1; // see [RULE8]
    end
    ctrl_wr_val[6] = 1'b0;
    ctrl_wr_val[2] = 1'b0;
  end

  assign stat_val = {5'h00, txrej_ff, !measuring, rxf_ff};
  assign rd_mux   = (reg_addr == uabd_pkg::ADDR_CTRL)      ? ctrl_ff :
                    (reg_addr == uabd_pkg::ADDR_RATE_LOW)  ? rate_ff[7:0] :
                    (reg_addr == uabd_pkg::ADDR_RATE_HIGH) ? rate_ff[15:8] :
                    (reg_addr == uabd_pkg::ADDR_STATUS)    ? stat_val :
                    (reg_addr == uabd_pkg::ADDR_TX_HOLD)   ? tx_data : 8'h00;

  // =====================================================================
  // registers
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state_ff      <= ST_IDLE;
      ctrl_ff       <= uabd_pkg::CTRL_RESET;
      rate_ff       <= 16'h0000;
      edges_ff      <= 3'h0;
      prev_level_ff <= 1'b1;
      break_seen_ff <= 1'b0;
      reg_rdata     <= 8'h00;
      rxf_ff        <= 1'b0;
      txrej_ff      <= 1'b0;
    end else begin
      state_ff      <= nxt_state;
      ctrl_ff       <= ctrl_wr_val;
      rate_ff       <= nxt_rate;
      edges_ff      <= nxt_edges;
      prev_level_ff <= level;
      // a falling edge in the start state marks the start bit
      break_seen_ff <= (nxt_state == ST_START) && (break_seen_ff || fall); // see [RULE2]
      reg_rdata     <= reg_rd ? rd_mux : 8'h00;
      // fifth edge sets the flag, set wins over the read that clears it
      rxf_ff        <= fifth || (rxf_ff && !rd_rx); // see [RULE14]
      // sticky reject of a transmit write while armed; a status write with bit 2 set clears
      txrej_ff      <= (wr_tx && armed) ||
                       (txrej_ff && !(wr_stat && reg_wdata[uabd_pkg::STAT_TXREJ_BIT]));
    end
  end

  // transmit holding and outputs
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tx_data            <= 8'h00;
      tx_write_ok        <= 1'b0;
      receiver_hold_idle <= 1'b0;
      receive_flag       <= 1'b0;
    end else begin
      if (wr_tx && !armed) begin
        tx_data <= reg_wdata; // see [RULE16]
      end
      tx_write_ok        <= wr_tx && !armed; // see [RULE16]
      receiver_hold_idle <= (nxt_state != ST_IDLE); // see [RULE13]
      receive_flag       <= fifth || (rxf_ff && !rd_rx);
    end
  end
endmodule

//--- uabd_properties.sv
// concurrent checks on the ports of the rate measurement block
module uabd_properties (
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_b,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // serial side and status
  input wire logic       serial_in_pin,
  input wire logic       receiver_hold_idle,
  input wire logic       receive_flag,
  input wire logic       tx_write_ok,
  input wire logic [7:0] tx_data
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire ctl_wr = reg_wr && reg_addr == uabd_pkg::ADDR_CTRL;
  wire tx_wr  = reg_wr && reg_addr == uabd_pkg::ADDR_TX_HOLD;
  wire w_arm  = reg_wdata[uabd_pkg::CTRL_ARM_BIT];
  wire w_asy  = reg_wdata[uabd_pkg::CTRL_ASYNC_BIT];
  wire w_wake = reg_wdata[uabd_pkg::CTRL_WAKE_BIT];
  // ====
  // measurement
  arm_starts_a:
    assert property (ctl_wr && w_arm && w_asy && !w_wake |=>
      receiver_hold_idle) else $error("arm write did not start measurement");
  async_gate_a:
    assert property (ctl_wr && !w_asy && !receiver_hold_idle |=> !receiver_hold_idle)
    else $error("measurement started outside async mode");
  end_flag_a:
    assert property ($fell(receiver_hold_idle) && !$past(reg_wr) |-> ##[0:2] receive_flag)
    else $error("measurement ended without receive flag");
  rx_read_clears_a:
    assert property (reg_rd && reg_addr == uabd_pkg::ADDR_RX_HOLD && !receiver_hold_idle |=>
      !receive_flag && reg_rdata == 8'h00) else $error("holding read left flag set");
  status_mirror_a:
    assert property (reg_rd && reg_addr == uabd_pkg::ADDR_STATUS |=>
      reg_rdata[uabd_pkg::STAT_IDLE_BIT] == !$past(receiver_hold_idle) &&
      reg_rdata[uabd_pkg::STAT_RXF_BIT] == $past(receive_flag))
    else $error("status read disagrees with outputs");
  unmapped_read_a:
    assert property (reg_rd && reg_addr > uabd_pkg::ADDR_TX_HOLD |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  // ====
  // transmit holding
  tx_block_a:
    assert property (tx_wr && receiver_hold_idle |=> !tx_write_ok)
    else $error("transmit write accepted while measuring");
  tx_accept_a:
    assert property (tx_wr && !receiver_hold_idle |=> tx_write_ok && tx_data == $past(reg_wdata))
    else $error("transmit write lost");
  tx_cause_a:
    assert property (tx_write_ok |-> $past(tx_wr)) else $error("transmit pulse without write");
  arm_c: cover property (ctl_wr && reg_wdata[0]);
  flag_c: cover property ($rose(receive_flag));
  txrej_c: cover property (tx_wr && receiver_hold_idle);
endmodule
bind uabd_top uabd_properties u_uabd_properties (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rdata, .serial_in_pin, .receiver_hold_idle, .receive_flag, .tx_write_ok, .tx_data);

//--- uabd_tx_model.sv
// behavioural remote transmitter sending calibration frames
module uabd_tx_model (
  // clock
  input wire logic clk,
  // serial line, idle high
  output logic     line
);
  timeunit 1ns;
  timeprecision 1ps;
  initial line = 1'b1;
  // 8n1 frame, lsb first, bit time t in system cycles
  task automatic send_byte(input logic [7:0] b, input int t);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line <= f[i];
      repeat (t) @(posedge clk);
    end
  endtask
  // long low then short idle marks a break
  task automatic send_break(input int t);
    line <= 1'b0;
    repeat (13 * t) @(posedge clk);
    line <= 1'b1;
    repeat (2 * t) @(posedge clk);
  endtask
endmodule

//--- uart_auto_baud_detect_tb.sv
// self-checking bench for the rate measurement block
module uart_auto_baud_detect_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk;
  logic       rst_b;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       serial_in_pin;
  logic       receiver_hold_idle;
  logic       receive_flag;
  logic       tx_write_ok;
  logic [7:0] tx_data;
  logic [7:0] rd_q;
  int         err_total;
  int         n_compared;
  uabd_top u_uabd_top (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .serial_in_pin, .receiver_hold_idle, .receive_flag, .tx_write_ok, .tx_data);
  uabd_tx_model u_uabd_tx_model (.clk, .line(serial_in_pin));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // ====
  // helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_q = reg_rdata;
  endtask
  // count is t/div; checked exactly, low byte 04 and high byte 00
  task automatic chk_rate;
    rd(uabd_pkg::ADDR_RATE_LOW);
    chk(rd_q, 8'h04);
    rd(uabd_pkg::ADDR_RATE_HIGH);
    chk(rd_q, 8'h00);
  endtask
  task automatic end_of_test;
    $display("compared=%0d errors=%0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ====
  // scenarios
  task automatic t_reset_vals;
    rd(uabd_pkg::ADDR_CTRL);
    chk(rd_q, uabd_pkg::CTRL_RESET);
    rd(uabd_pkg::ADDR_STATUS);
    chk(rd_q, 8'h02);
    rd(4'h9);
    chk(rd_q, 8'h00);
  endtask
  task automatic t_roll_sw;
    wr(uabd_pkg::ADDR_CTRL, 8'ha0);
    rd(uabd_pkg::ADDR_CTRL);
    chk(rd_q, 8'ha0);
    wr(uabd_pkg::ADDR_CTRL, 8'h20);
    rd(uabd_pkg::ADDR_CTRL);
    chk(rd_q, 8'h20);
  endtask
  task automatic t_async_off;
    wr(uabd_pkg::ADDR_CTRL, 8'h01);
    #1 chk(receiver_hold_idle, 1'b0);
    wr(uabd_pkg::ADDR_CTRL, uabd_pkg::CTRL_RESET);
  endtask
  // sel is {wide, high}; line is idle when armed
  task automatic t_measure(input logic [1:0] sel, input int t);
    wr(uabd_pkg::ADDR_CTRL, {3'h1, sel[0], sel[1], 3'h1});
    #1 chk(receiver_hold_idle, 1'b1);
    rd(uabd_pkg::ADDR_RATE_LOW);
    chk(rd_q, 8'h00);
    u_uabd_tx_model.send_byte(uabd_pkg::CAL_CHAR, t);
    chk_rate;
    rd(uabd_pkg::ADDR_CTRL);
    chk(rd_q, {3'h1, sel[0], sel[1], 3'h0});
    chk(receive_flag, 1'b1);
    chk(receiver_hold_idle, 1'b0);
    rd(uabd_pkg::ADDR_RX_HOLD);
    chk(receive_flag, 1'b0);
  endtask
  task automatic t_tx_block;
    wr(uabd_pkg::ADDR_TX_HOLD, 8'h3c);
    #1 chk(tx_write_ok, 1'b1);
    wr(uabd_pkg::ADDR_CTRL, 8'h39);
    wr(uabd_pkg::ADDR_TX_HOLD, 8'hc3);
    #1 chk(tx_write_ok, 1'b0);
    chk(tx_data, 8'h3c);
    rd(uabd_pkg::ADDR_STATUS);
    chk(rd_q & 8'h04, 8'h04);
    wr(uabd_pkg::ADDR_STATUS, 8'h04);
    rd(uabd_pkg::ADDR_STATUS);
    chk(rd_q & 8'h04, 8'h00);
    u_uabd_tx_model.send_byte(uabd_pkg::CAL_CHAR, 4 * uabd_pkg::DIV_FAST);
    rd(uabd_pkg::ADDR_RX_HOLD);
  endtask
  task automatic t_wake;
    wr(uabd_pkg::ADDR_CTRL, 8'h3b);
    u_uabd_tx_model.send_break(4 * uabd_pkg::DIV_FAST);
    u_uabd_tx_model.send_byte(uabd_pkg::CAL_CHAR, 4 * uabd_pkg::DIV_FAST);
    chk_rate;
    chk(receive_flag, 1'b1);
    rd(uabd_pkg::ADDR_RX_HOLD);
  endtask
  initial begin
    rst_b = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    err_total = 0;
    n_compared = 0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    t_reset_vals;
    t_roll_sw;
    t_async_off;
    t_measure(2'h0, 4 * uabd_pkg::DIV_SLOW);
    t_measure(2'h1, 4 * uabd_pkg::DIV_MID);
    t_measure(2'h2, 4 * uabd_pkg::DIV_MID);
    t_measure(2'h3, 4 * uabd_pkg::DIV_FAST);
    t_tx_block;
    t_wake;
    end_of_test;
  end
  // run needs about 40k cycles; twice that cuts a hang
  initial begin
    #1_600_000;
    err_total++;
    end_of_test;
  end
endmodule
